/* File: hw/pg2r_consts.vh */
// Purpose: Constants for the page-2 trim and efficiency register bank.
// Assumes: 16-bit management registers, 5-bit register number.
// Notes:   Offsets are register numbers; values are 16-bit.
`ifndef PG2R_CONSTS_VH
`define PG2R_CONSTS_VH

`define PG2R_REG_PAGE        5'h1F
`define PG2R_REG_TRIM        5'h10
`define PG2R_REG_EFF         5'h11
`define PG2R_REG_CTRL0       5'h00
`define PG2R_PAGE_MAIN       16'h0000
`define PG2R_PAGE_TWO        16'h0002
`define PG2R_TRIM_RESET      16'h028E
`define PG2R_EFF_RESET       16'h0000
`define PG2R_EFF_WMASK       16'h8C3F
`define PG2R_CTRL0_SPD_LSB   6
`define PG2R_CTRL0_SPD_MSB   13
`define PG2R_EFF_TE_BIT      15
`define PG2R_EFF_LINK_BIT    8
`define PG2R_EFF_GEEE_BIT    7
`define PG2R_EFF_FEEE_BIT    6
`define PG2R_EFF_FORCE_BIT   5
`define PG2R_EFF_FLPI_BIT    4
`define PG2R_EFF_FTXI_BIT    3
`define PG2R_EFF_FRXI_BIT    2
`define PG2R_EFF_GTXI_BIT    1
`define PG2R_EFF_GRXI_BIT    0
`define PG2R_EFF_LED_LSB     10
`define PG2R_TRIM_GIG_LSB    12
`define PG2R_TRIM_FAST_LSB   8
`define PG2R_TRIM_TEN_LSB    4
`define PG2R_TRIM_TEN_EFF_LSB 0
`define PG2R_TRIM_GIG_RESET  4'h0
`define PG2R_TRIM_FAST_RESET 4'h2
`define PG2R_TRIM_TEN_RESET  4'h8
`define PG2R_TRIM_TEN_EFF_RESET 4'hE
`define PG2R_EFF_TE_RESET    1'b0
`define PG2R_EFF_LED_RESET   2'b00
`define PG2R_EFF_BIT_RESET   1'b0

`endif

/* File: hw/pg2r_regs.v */
// Purpose: Page-2 register bank: transmit amplitude trim and efficiency control.
// Assumes: Plain register port, read data valid one cycle after the read strobe.
// Notes:   Standard registers 0-15 and page-1/main 16-30 live outside; this block
//          steers each access and muxes the returned data.
//          Register 31 is held here in full and never forwarded outside.
//          Page-2 slots 18-30 have no storage: they read zero, writes drop.
//          Every stored field is sticky; only the hardware reset restores it.
//          Status bits 8:6 of the efficiency slot are live input levels.
//          Forced idle overrides both transmit inhibits on the line side.
//          The filtered idles and the steering strobes are combinational.
//          Trim codes reach the analog transmitter exactly as stored.
//          The manager keeps the debug bits 4:0 at zero in normal use.
`timescale 1ns/100ps
`include "pg2r_consts.vh"

module pg2r_regs (
   // Clock and reset
   input  wire        CLOCK_I,
   input  wire        RESET_N_I,
   // Register port
   input  wire [4:0]  ADDR_I,
   input  wire [15:0] WDATA_I,
   input  wire        WR_I,
   input  wire        RD_I,
   output reg  [15:0] RDATA_O,
   // Standard register space outside this block
   output wire        STD_WR_O,
   output wire        STD_RD_O,
   input  wire [15:0] STD_RDATA_I,
   input  wire [15:0] CTRL0_I,
   // Line status inputs
   input  wire        LINK_UP_I,
   input  wire        GIG_EEE_I,
   input  wire        FAST_EEE_I,
   input  wire        SPEED_GIG_I,
   input  wire        SPEED_FAST_I,
   // Idle indications
   input  wire        MAC_LPI_I,
   input  wire        LINE_LPI_I,
   output wire        LINE_LPI_O,
   output wire        MAC_LPI_O,
   // Steering outputs
   output wire        PAGE2_SEL_O,
   output wire [3:0]  TRIM_GIG_O,
   output wire [3:0]  TRIM_FAST_O,
   output wire [3:0]  TRIM_TEN_O,
   output wire [3:0]  TRIM_TEN_EFF_O,
   output wire        TEN_EFF_EN_O,
   output wire [1:0]  LED_INVERT_O,
   output wire        FORCE_GIG_O,
   output wire        FORCE_LPI_O
);

   // ==========================================================
   // Storage and decode
   reg  [15:0] page;
   reg  [3:0]  trim_gig;
   reg  [3:0]  trim_fast;
   reg  [3:0]  trim_ten;
   reg  [3:0]  trim_ten_eff;
   reg         ten_eff_en;
   reg  [1:0]  led_invert;
   reg         force_gig_en;
   reg         force_lpi;
   reg         inhibit_fast_tx;
   reg         inhibit_fast_rx;
   reg         inhibit_gig_tx;
   reg         inhibit_gig_rx;
   reg  [3:0]  next_trim_gig;
   reg  [3:0]  next_trim_fast;
   reg  [3:0]  next_trim_ten;
   reg  [3:0]  next_trim_ten_eff;
   reg         next_ten_eff_en;
   reg  [1:0]  next_led_invert;
   reg         next_force_gig_en;
   reg         next_force_lpi;
   reg         next_inhibit_fast_tx;
   reg         next_inhibit_fast_rx;
   reg         next_inhibit_gig_tx;
   reg         next_inhibit_gig_rx;
   reg  [15:0] next_rdata;
   wire        pg2;
   wire        page_hit;
   wire        local_hit;
   wire        trim_hit;
   wire        eff_hit;
   wire        page_wr;
   wire        trim_wr;
   wire        eff_wr;
   wire [15:0] trim_word;
   wire [15:0] eff_view;
   wire        speed_ok;

   // ==========================================================
   // Helpers
   // A page-2 register is one of 16-30 while page two is selected.
   function is_page2_slot;
      input [4:0] a;
      input       sel;
      begin
         is_page2_slot = sel && (a >= 5'h10) && (a != `PG2R_REG_PAGE);
      end
   endfunction

   // An idle indication passes unless the inhibit for the current speed is set.
   function lpi_pass;
      input lpi;
      input fast;
      input gig;
      input inhibit_fast;
      input inhibit_gig;
      begin
         lpi_pass = lpi && !(fast && inhibit_fast) && !(gig && inhibit_gig);
      end
   endfunction

   // ==========================================================
   // Page select and steering of accesses
   assign pg2         = (page == `PG2R_PAGE_TWO);
   assign page_hit    = (ADDR_I == `PG2R_REG_PAGE);
   assign local_hit   = is_page2_slot(ADDR_I, pg2);
   assign trim_hit    = local_hit && (ADDR_I == `PG2R_REG_TRIM);
   assign eff_hit     = local_hit && (ADDR_I == `PG2R_REG_EFF);
   assign page_wr     = WR_I && page_hit;
   assign trim_wr     = WR_I && trim_hit;
   assign eff_wr      = WR_I && eff_hit;
   // Register 31 is never forwarded, so the outside set cannot shadow it.
   assign STD_WR_O    = WR_I && !local_hit && !page_hit;
   assign STD_RD_O    = RD_I && !local_hit && !page_hit;
   assign PAGE2_SEL_O = pg2;

   // ==========================================================
   // Next values of the stored fields
   // Reserved and read-only bits of a written word are simply not taken,
   // so a write can never disturb them.
   always @* begin
      next_trim_gig        = trim_gig;
      next_trim_fast       = trim_fast;
      next_trim_ten        = trim_ten;
      next_trim_ten_eff    = trim_ten_eff;
      next_ten_eff_en      = ten_eff_en;
      next_led_invert      = led_invert;
      next_force_gig_en    = force_gig_en;
      next_force_lpi       = force_lpi;
      next_inhibit_fast_tx = inhibit_fast_tx;
      next_inhibit_fast_rx = inhibit_fast_rx;
      next_inhibit_gig_tx  = inhibit_gig_tx;
      next_inhibit_gig_rx  = inhibit_gig_rx;
      if (trim_wr) begin
         next_trim_gig     = WDATA_I[`PG2R_TRIM_GIG_LSB +: 4];
         next_trim_fast    = WDATA_I[`PG2R_TRIM_FAST_LSB +: 4];
         next_trim_ten     = WDATA_I[`PG2R_TRIM_TEN_LSB +: 4];
         next_trim_ten_eff = WDATA_I[`PG2R_TRIM_TEN_EFF_LSB +: 4];
      end
      if (eff_wr) begin
         next_ten_eff_en      = WDATA_I[`PG2R_EFF_TE_BIT];
         next_led_invert      = WDATA_I[`PG2R_EFF_LED_LSB +: 2];
         next_force_gig_en    = WDATA_I[`PG2R_EFF_FORCE_BIT];
         next_force_lpi       = WDATA_I[`PG2R_EFF_FLPI_BIT];
         next_inhibit_fast_tx = WDATA_I[`PG2R_EFF_FTXI_BIT];
         next_inhibit_fast_rx = WDATA_I[`PG2R_EFF_FRXI_BIT];
         next_inhibit_gig_tx  = WDATA_I[`PG2R_EFF_GTXI_BIT];
         next_inhibit_gig_rx  = WDATA_I[`PG2R_EFF_GRXI_BIT];
      end
   end

   // ==========================================================
   // Page register
   // Stored in full; only the exact page-two code selects page two.
   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         page <= `PG2R_PAGE_MAIN;
      end else if (page_wr) begin
         page <= WDATA_I;
      end
   end

   // ==========================================================
   // Transmit amplitude trim
   // Only the hardware reset restores these; there is no soft reset path,
   // so every trim field is kept through a software reset.
   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         trim_gig <= `PG2R_TRIM_GIG_RESET;
      end else begin
         trim_gig <= next_trim_gig;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         trim_fast <= `PG2R_TRIM_FAST_RESET;
      end else begin
         trim_fast <= next_trim_fast;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         trim_ten <= `PG2R_TRIM_TEN_RESET;
      end else begin
         trim_ten <= next_trim_ten;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         trim_ten_eff <= `PG2R_TRIM_TEN_EFF_RESET;
      end else begin
         trim_ten_eff <= next_trim_ten_eff;
      end
   end

   // ==========================================================
   // Efficiency control fields
   // Bits 4:0 are debug controls; forced idle takes over the line side
   // for as long as it is set.
   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ten_eff_en <= `PG2R_EFF_TE_RESET;
      end else begin
         ten_eff_en <= next_ten_eff_en;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         led_invert <= `PG2R_EFF_LED_RESET;
      end else begin
         led_invert <= next_led_invert;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         force_gig_en <= `PG2R_EFF_BIT_RESET;
      end else begin
         force_gig_en <= next_force_gig_en;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         force_lpi <= `PG2R_EFF_BIT_RESET;
      end else begin
         force_lpi <= next_force_lpi;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         inhibit_fast_tx <= `PG2R_EFF_BIT_RESET;
      end else begin
         inhibit_fast_tx <= next_inhibit_fast_tx;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         inhibit_fast_rx <= `PG2R_EFF_BIT_RESET;
      end else begin
         inhibit_fast_rx <= next_inhibit_fast_rx;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         inhibit_gig_tx <= `PG2R_EFF_BIT_RESET;
      end else begin
         inhibit_gig_tx <= next_inhibit_gig_tx;
      end
   end

   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         inhibit_gig_rx <= `PG2R_EFF_BIT_RESET;
      end else begin
         inhibit_gig_rx <= next_inhibit_gig_rx;
      end
   end

   // ==========================================================
   // Read view
   // Status bits are live levels; reserved bits always read zero.
   assign trim_word = {trim_gig, trim_fast, trim_ten, trim_ten_eff};
   assign eff_view  = {ten_eff_en,
                       3'h0,
                       led_invert,
                       1'b0,
                       LINK_UP_I,
                       GIG_EEE_I,
                       FAST_EEE_I,
                       force_gig_en,
                       force_lpi,
                       inhibit_fast_tx,
                       inhibit_fast_rx,
                       inhibit_gig_tx,
                       inhibit_gig_rx};

   always @* begin
      next_rdata = 16'h0000;
      if (page_hit) begin
         next_rdata = page;
      end else if (trim_hit) begin
         next_rdata = trim_word;
      end else if (eff_hit) begin
         next_rdata = eff_view;
      end else if (local_hit) begin
         // Page-2 slots without storage read zero.
         next_rdata = 16'h0000;
      end else begin
         next_rdata = STD_RDATA_I;
      end
   end

   // The outside set answers in the strobe cycle; the word is captured here
   // and shown for one cycle only, so a stale value never looks valid.
   always @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RDATA_O <= 16'h0000;
      end else if (RD_I) begin
         RDATA_O <= next_rdata;
      end else begin
         RDATA_O <= 16'h0000;
      end
   end

   // ==========================================================
   // Steering of the transceiver
   assign TRIM_GIG_O     = trim_gig;
   assign TRIM_FAST_O    = trim_fast;
   assign TRIM_TEN_O     = trim_ten;
   assign TRIM_TEN_EFF_O = trim_ten_eff;
   assign TEN_EFF_EN_O   = ten_eff_en;
   assign LED_INVERT_O   = led_invert;
   // Control register 0 bits 6 and 13 must read 2'b10, the gigabit code.
   assign speed_ok       = CTRL0_I[`PG2R_CTRL0_SPD_LSB] &&
                           !CTRL0_I[`PG2R_CTRL0_SPD_MSB];
   assign FORCE_GIG_O    = force_gig_en && speed_ok;
   assign FORCE_LPI_O    = force_lpi;

   // ==========================================================
   // Idle filtering
   // Forced idle wins over both transmit inhibits: the frame generator then owns the
   // transmit path and the idles from the MAC are ignored.
   assign LINE_LPI_O = force_lpi ||
                       lpi_pass(MAC_LPI_I, SPEED_FAST_I, SPEED_GIG_I,
                                inhibit_fast_tx, inhibit_gig_tx);
   assign MAC_LPI_O  = lpi_pass(LINE_LPI_I, SPEED_FAST_I, SPEED_GIG_I,
                                inhibit_fast_rx, inhibit_gig_rx);

endmodule

/* File: tb/pg2r_regs_asserts.sv */
// Purpose: Port checks for pg2r_regs.
// Assumes: One clock, reset async low.
// Notes:   Attached by bind.
`timescale 1ns/100ps
module pg2r_regs_asserts (
   input wire        CLOCK_I, RESET_N_I, WR_I, RD_I, STD_WR_O, STD_RD_O, PAGE2_SEL_O,
   input wire        LINK_UP_I, FORCE_GIG_O, FORCE_LPI_O, LINE_LPI_O,
   input wire [4:0]  ADDR_I,
   input wire [15:0] WDATA_I, RDATA_O, CTRL0_I,
   input wire [3:0]  TRIM_GIG_O, TRIM_FAST_O, TRIM_TEN_O, TRIM_TEN_EFF_O
);
   // ====
   // Checks
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   a_page_two: assert property (WR_I && ADDR_I == 5'h1F && WDATA_I == 16'h0002 |=> PAGE2_SEL_O)
      else $error("page two not selected");
   a_page_main: assert property (WR_I && ADDR_I == 5'h1F && WDATA_I == 16'h0000 |=> !PAGE2_SEL_O)
      else $error("main page not restored");
   a_low_std: assert property (ADDR_I < 5'h10 |-> STD_WR_O == WR_I && STD_RD_O == RD_I)
      else $error("low register not forwarded");
   a_page2_hide: assert property (PAGE2_SEL_O && ADDR_I[4] |-> !STD_WR_O && !STD_RD_O)
      else $error("page two access leaked");
   a_trim_read: assert property (RD_I && PAGE2_SEL_O && ADDR_I == 5'h10 |=>
      RDATA_O == {TRIM_GIG_O, TRIM_FAST_O, TRIM_TEN_O, TRIM_TEN_EFF_O}) else $error("trim readback wrong");
   a_eff_read: assert property (RD_I && PAGE2_SEL_O && ADDR_I == 5'h11 |=>
      RDATA_O[14:12] == 3'h0 && !RDATA_O[9] && RDATA_O[8] == $past(LINK_UP_I)) else $error("status wrong");
   a_force_gig: assert property (FORCE_GIG_O |-> CTRL0_I[6] && !CTRL0_I[13])
      else $error("forced gigabit without speed");
   a_force_idle: assert property (FORCE_LPI_O |-> LINE_LPI_O)
      else $error("forced idle missing");
endmodule
bind pg2r_regs pg2r_regs_asserts pg2r_regs_asserts_i (.*);

/* File: tb/pg2r_regs_tb.sv */
// Purpose: Self-checking bench for pg2r_regs.
// Assumes: 40 MHz clock, reset held ten cycles.
// Notes:   Values from a fixed seed.
`timescale 1ns/100ps
module pg2r_regs_tb;
   reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, link = 1'b0, geee = 1'b0, feee = 1'b0;
   reg         sg = 1'b0, sf = 1'b0, mlpi = 1'b0, llpi = 1'b0;
   reg  [4:0]  addr = 5'h00;
   reg  [15:0] wdata = 16'h0000, ctrl0 = 16'h0000, v;
   wire [15:0] rdata, srd;
   wire        swr, srdd, line_o, mac_o, p2, fgig, flpi, ten;
   wire [1:0]  led;
   wire [3:0]  tg, tf, tt, tte;
   integer     mismatches = 0, checks = 0, seed = 32'hBF3849EA, cyc = 0, b;
   always #12.5 clk = ~clk;
   pg2r_std_model pg2r_std_model_i (.clock_i(clk), .wr_i(swr), .rd_i(srdd), .addr_i(addr), .wdata_i(wdata),
      .rdata_o(srd));
   pg2r_regs pg2r_regs_i (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .STD_WR_O(swr), .STD_RD_O(srdd), .STD_RDATA_I(srd), .CTRL0_I(ctrl0),
      .LINK_UP_I(link), .GIG_EEE_I(geee), .FAST_EEE_I(feee), .SPEED_GIG_I(sg), .SPEED_FAST_I(sf),
      .MAC_LPI_I(mlpi), .LINE_LPI_I(llpi), .LINE_LPI_O(line_o), .MAC_LPI_O(mac_o), .PAGE2_SEL_O(p2),
      .TRIM_GIG_O(tg), .TRIM_FAST_O(tf), .TRIM_TEN_O(tt), .TRIM_TEN_EFF_O(tte), .TEN_EFF_EN_O(ten),
      .LED_INVERT_O(led),
      .FORCE_GIG_O(fgig), .FORCE_LPI_O(flpi));
   task chk(input [47:0] n, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task wr16(input [4:0] a, input [15:0] d);
      begin
         wr <= 1'b1; addr <= a; wdata <= d;
         @(posedge clk); wr <= 1'b0; @(posedge clk);
      end
   endtask
   task rd16(input [4:0] a, input [15:0] e);
      begin
         rd <= 1'b1; addr <= a;
         @(posedge clk); rd <= 1'b0;
         @(negedge clk); chk("rdata", e, rdata); @(posedge clk);
      end
   endtask
   function [15:0] eff_exp(input [15:0] w);
      eff_exp = (w & 16'h8C3F) | {7'h00, link, geee, feee, 6'h00};
   endfunction
   task give_verdict;
      begin
         if (mismatches == 0 && checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1; give_verdict;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1; @(posedge clk);
      wr16(5'h1F, 16'h0002); rd16(5'h1F, 16'h0002);
      chk("page", 16'h0001, {15'h0, p2});
      rd16(5'h10, 16'h028E);
      v = $random(seed); {link, geee, feee} <= v[2:0];
      wr16(5'h11, v); rd16(5'h11, eff_exp(v));
      chk("te", {15'h0, v[15]}, {15'h0, ten});
      chk("led", {14'h0, v[11:10]}, {14'h0, led});
      for (b = 0; b < 8; b = b + 1) begin
         v = $random(seed);
         wr16(5'h10, v); rd16(5'h10, v);
         chk("trim", v, {tg, tf, tt, tte});
      end
      wr16(5'h05, ~v); rd16(5'h05, ~v);
      wr16(5'h1F, 16'h0000); rd16(5'h10, 16'h0000);
      chk("page", 16'h0000, {15'h0, p2});
      wr16(5'h1F, 16'h0002); {mlpi, llpi} <= 2'b11;
      for (b = 0; b < 4; b = b + 1) begin
         sg <= b < 2; sf <= b >= 2;
         wr16(5'h11, 16'h0001 << b);
         chk("line", {15'h0, ~b[0]}, {15'h0, line_o});
         chk("mac", {15'h0, b[0]}, {15'h0, mac_o});
      end
      mlpi <= 1'b0; ctrl0 <= 16'h0040;
      wr16(5'h11, 16'h0030);
      chk("lpi", 16'h0001, {15'h0, line_o});
      chk("gig", 16'h0001, {15'h0, fgig});
      chk("flpi", 16'h0001, {15'h0, flpi});
      ctrl0 <= 16'h2040; @(negedge clk);
      chk("nogig", 16'h0000, {15'h0, fgig});
      @(posedge clk); wr16(5'h11, 16'h0000);
      chk("flpi", 16'h0000, {15'h0, flpi});
      rst_n <= 1'b0; repeat (2) @(posedge clk);
      rst_n <= 1'b1; @(negedge clk);
      chk("rtrim", 16'h028E, {tg, tf, tt, tte});
      chk("rpage", 16'h0000, {15'h0, p2});
      chk("rled", 16'h0000, {13'h0, led, ten});
      give_verdict;
   end
endmodule

/* File: tb/pg2r_std_model.sv */
// Purpose: Standard register set beside the page-2 bank.
// Assumes: Read data combinational in the strobe cycle.
// Notes:   Off-strobe data is inverted so stale values never pass.
`timescale 1ns/100ps
module pg2r_std_model (
   input  wire        clock_i, wr_i, rd_i,
   input  wire [4:0]  addr_i,
   input  wire [15:0] wdata_i,
   output wire [15:0] rdata_o
);
   reg     [15:0] mem [0:31];
   integer        i;
   initial for (i = 0; i < 32; i = i + 1) mem[i] = 16'h0000;
   assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
   always @(posedge clock_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule
